// *** include/epir_pkg.sv ***
// Package: offsets, field layouts and reset values of the register block
package epir_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_IRQ_EN = 8'h14;
    localparam logic [7:0] OFF_CTRL_FN = 8'h28;
    localparam logic [7:0] OFF_EP_SEL = 8'h2C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    // Interrupt enable bit positions (low byte)
    localparam int IE_SUPPLY = 7;
    localparam int IE_DMA = 6;
    localparam int IE_SPEED = 5;
    localparam int IE_RESUME = 4;
    localparam int IE_SUSPEND = 3;
    localparam int IE_PSOF = 2;
    localparam int IE_SOF = 1;
    localparam int IE_BRST = 0;
    localparam int NUM_EVT = 8;
    localparam logic [7:0] IE_RST_VAL = 8'h00;
    localparam logic [7:0] IE_BUSRST_VAL = 8'h01;
    // Endpoint selector layout
    localparam int SEL_SETUP = 5;
    localparam int SEL_EP_HI = 4;
    localparam int SEL_EP_LO = 1;
    localparam int SEL_DIR = 0;
    localparam logic [5:0] SEL_RST_VAL = 6'h20;
    localparam logic [5:0] SEL_WR_MASK = 6'h3F;
    // Control function layout
    localparam int CF_FLUSH = 4;
    localparam int CF_VALID = 3;
    localparam int CF_DATA_STAGE_EN = 2;
    localparam int CF_STATUS = 1;
    localparam int CF_STALL = 0;
    localparam logic [4:0] CF_RST_VAL = 5'h00;
    localparam logic [4:0] CF_RD_MASK = 5'h1B;
endpackage : epir_pkg

// *** include/epir_if.sv ***
// Interface joining the register block to its controller
`timescale 1ns/1ps
interface epir_if;
    import epir_pkg::*;
    logic [ADDR_W-1:0] regAddr;
    logic regWr;
    logic regRd;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic irqLine;
    modport dev (input regAddr, input regWr, input regRd, input regWdata,
                 output regRdata, output irqLine);
    modport ctl (output regAddr, output regWr, output regRd,
                 output regWdata, input regRdata, input irqLine);
endinterface : epir_if

// *** hw/epir_device.sv ***
// Device end: interrupt enables, endpoint selector, control function
// What this block does
// RULE1 - Bit 7 gates supply sensing interrupt
// RULE2 - Bit 6 gates DMA reason change interrupt
// RULE3 - Bit 5 gates speed change interrupt
// RULE4 - Bit 4 resume, bit 3 suspend gates
// RULE5 - Bit 2 gates pseudo frame interrupt
// RULE6 - Bit 1 gates frame start interrupt
// RULE7 - Bit 0 gates bus reset interrupt
// RULE8 - Bus reset clears enables except bit 0
// RULE9 - Selector at 2Ch routes indexed register accesses
// RULE10 - Endpoint select in bits 4 to 1
// RULE11 - Controller never aliases selector and DMA endpoint
// RULE12 - Wait 190 ns before data port read
// RULE13 - Wait 100 ns before data port write
// RULE14 - Bit 5 selects endpoint 0 setup buffer
// RULE15 - Controller keeps setup bit low otherwise
// RULE16 - Bit 0 picks OUT or IN FIFO
// RULE17 - Endpoint 0 buffers decode from three fields
// RULE18 - Resets: setup bit 1, bus reset keeps it
// RULE19 - Controller sets selector before control function
// RULE20 - Control function bits flush, validate, stage, status, stall
// RULE21 - Interrupt only for pending enabled events
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module epir_device
    import epir_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    epir_if.dev bus,
    input wire logic usbBusReset,
    input wire logic [NUM_EVT-1:0] eventPulse,
    input wire logic [NUM_EVT-1:0] eventClear,
    input wire logic dataStageDone,
    input wire logic statusDone,
    output logic [3:0] selEndpoint,
    output logic selDirIn,
    output logic selSetupBuf,
    output logic selCtrlOut,
    output logic selCtrlIn,
    output logic selDataEp,
    output logic flushPulse,
    output logic validatePulse,
    output logic dataStageEn,
    output logic statusAck,
    output logic stallEp,
    output logic [NUM_EVT-1:0] eventPending
);
    logic [7:0] irqEn_q;
    logic [5:0] sel_q;
    logic [4:0] cf_q;
    logic [NUM_EVT-1:0] pend_q;
    logic [7:0] rdata_q;
    logic wrIe, wrSel, wrCf;

    assign wrIe = bus.regWr && bus.regAddr == OFF_IRQ_EN;
    assign wrSel = bus.regWr && bus.regAddr == OFF_EP_SEL;
    assign wrCf = bus.regWr && bus.regAddr == OFF_CTRL_FN;

    // ------------------------------------------------------------
    // Interrupt enables
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irqEn_q <= IE_RST_VAL;
        end else if (usbBusReset) begin
            irqEn_q <= IE_BUSRST_VAL; // RULE8
        end else if (wrIe) begin
            irqEn_q <= bus.regWdata;
        end
    end

    // Set wins over clear so no event is lost
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~eventClear) | eventPulse;
        end
    end
    assign eventPending = pend_q;

    // Each bit of the enable byte gates its own event
    // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7
    assign bus.irqLine = |(pend_q & irqEn_q); // RULE21

    // ------------------------------------------------------------
    // Endpoint selector
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sel_q <= SEL_RST_VAL; // RULE18
        end else if (usbBusReset) begin
            sel_q <= {sel_q[SEL_SETUP], 5'h00}; // RULE18
        end else if (wrSel) begin
            sel_q <= bus.regWdata[5:0] & SEL_WR_MASK; // RULE9
        end
    end
    assign selEndpoint = sel_q[SEL_EP_HI:SEL_EP_LO]; // RULE10
    assign selDirIn = sel_q[SEL_DIR]; // RULE16
    assign selSetupBuf = sel_q[SEL_SETUP] && selEndpoint == 4'h0
                         && !selDirIn; // RULE14 RULE17
    assign selCtrlOut = !sel_q[SEL_SETUP] && selEndpoint == 4'h0
                        && !selDirIn; // RULE17
    assign selCtrlIn = !sel_q[SEL_SETUP] && selEndpoint == 4'h0
                       && selDirIn; // RULE17
    assign selDataEp = selEndpoint != 4'h0; // RULE17

    // ------------------------------------------------------------
    // Control function of the selected endpoint
    // ------------------------------------------------------------
    // Flush and validate are commands: one-cycle pulses, never stored
    always_ff @(posedge clock) begin
        if (sys_rst || usbBusReset) begin
            cf_q <= CF_RST_VAL; // RULE20
        end else begin
            cf_q[CF_FLUSH] <= wrCf && bus.regWdata[CF_FLUSH];
            cf_q[CF_VALID] <= wrCf && bus.regWdata[CF_VALID];
            if (wrCf && bus.regWdata[CF_DATA_STAGE_EN]) begin
                cf_q[CF_DATA_STAGE_EN] <= 1'b1;
            end else if (dataStageDone) begin
                cf_q[CF_DATA_STAGE_EN] <= 1'b0;
            end
            if (wrCf) begin
                cf_q[CF_STATUS] <= bus.regWdata[CF_STATUS];
                cf_q[CF_STALL] <= bus.regWdata[CF_STALL];
            end else if (statusDone) begin
                cf_q[CF_STATUS] <= 1'b0;
            end
        end
    end
    assign flushPulse = cf_q[CF_FLUSH]; // RULE20
    assign validatePulse = cf_q[CF_VALID];
    assign dataStageEn = cf_q[CF_DATA_STAGE_EN];
    assign statusAck = cf_q[CF_STATUS];
    assign stallEp = cf_q[CF_STALL];

    // ------------------------------------------------------------
    // Read path: data one cycle after the read strobe
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (bus.regRd) begin
            unique case (bus.regAddr)
                OFF_IRQ_EN: rdata_q <= irqEn_q;
                OFF_EP_SEL: rdata_q <= {2'b00, sel_q};
                // Data stage enable is write-only and reads as zero
                OFF_CTRL_FN: rdata_q <= {3'b000, cf_q & CF_RD_MASK};
                OFF_IRQ_STAT: rdata_q <= pend_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end
    assign bus.regRdata = rdata_q;
endmodule : epir_device

// *** hw/epir_ctrl.sv ***
// Controller end: Avalon-MM slave registers drive the device's byte bus
`timescale 1ns/1ps
module epir_ctrl
    import epir_pkg::*;
#(
    parameter int unsigned CLK_HZ = 20000000
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    epir_if.ctl link,
    input wire logic dataPortRd,
    input wire logic dataPortWr,
    output logic dataPortGo
);
    // Settling times after a selector write, rounded up to whole cycles
    localparam int RD_GAP_NS = 190;
    localparam int WR_GAP_NS = 100;
    localparam int RD_GAP_CYC =
        (RD_GAP_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int WR_GAP_CYC =
        (WR_GAP_NS * (CLK_HZ / 1000000) + 999) / 1000;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00, S_ISSUE = 2'b01, S_WAIT = 2'b11, S_DONE = 2'b10
    } epir_state_e;
    epir_state_e state_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] wdata_q;
    logic isWr_q;
    logic [31:0] rdata_q;
    logic [7:0] gap_q;
    logic selWrite;

    // ------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: if (avs_read || avs_write) state_q <= S_ISSUE;
                S_ISSUE: state_q <= isWr_q ? S_DONE : S_WAIT;
                S_WAIT: state_q <= S_DONE;
                S_DONE: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            addr_q <= '0;
            wdata_q <= 8'h00;
            isWr_q <= 1'b0;
        end else if (state_q == S_IDLE && (avs_read || avs_write)) begin
            addr_q <= avs_address;
            wdata_q <= avs_writedata[7:0];
            isWr_q <= avs_write;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (state_q == S_WAIT) begin
            rdata_q <= {24'h00_0000, link.regRdata};
        end
    end

    assign link.regAddr = addr_q;
    assign link.regWdata = wdata_q;
    assign link.regWr = state_q == S_ISSUE && isWr_q;
    assign link.regRd = state_q == S_ISSUE && !isWr_q;
    assign avs_waitrequest = state_q != S_DONE;
    assign avs_readdata = rdata_q;

    // ------------------------------------------------------------
    // Data port settling guard after a selector write
    // ------------------------------------------------------------
    // RULE11 RULE15 RULE19 are kept by software through this port
    assign selWrite = link.regWr && addr_q == OFF_EP_SEL;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gap_q <= 8'h00;
        end else if (selWrite) begin
            gap_q <= 8'h00;
        end else if (gap_q != 8'hFF) begin
            gap_q <= gap_q + 8'h01;
        end
    end
    assign dataPortGo = (dataPortRd && int'(gap_q) >= RD_GAP_CYC) // RULE12
                     || (dataPortWr && int'(gap_q) >= WR_GAP_CYC); // RULE13
endmodule : epir_ctrl

// *** tb/epir_chk.sv ***
// Checker on the register link between the two ends
`timescale 1ns/1ps
module epir_chk
    import epir_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic usbBusReset,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic irqLine,
    input wire logic [NUM_EVT-1:0] eventPending
);
    logic [7:0] ie_q;
    logic [5:0] sel_q;
    logic stall_q;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ----
    // Shadow of the stored fields
    // ----
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ie_q <= IE_RST_VAL;
            sel_q <= SEL_RST_VAL;
            stall_q <= 1'b0;
        end else if (usbBusReset) begin
            ie_q <= IE_BUSRST_VAL;
            sel_q <= {sel_q[SEL_SETUP], 5'h00};
            stall_q <= 1'b0;
        end else if (regWr) begin
            if (regAddr == OFF_IRQ_EN) ie_q <= regWdata;
            if (regAddr == OFF_EP_SEL) sel_q <= regWdata[5:0];
            if (regAddr == OFF_CTRL_FN) stall_q <= regWdata[CF_STALL];
        end
    end
    chk_irq_gated: assert property (irqLine == |(eventPending & ie_q))
        else $error("irq line disagrees with enabled pending events");
    chk_ie_readback: assert property (regRd && regAddr == OFF_IRQ_EN
        |=> regRdata == ie_q) else $error("enable readback wrong");
    chk_sel_readback: assert property (regRd && regAddr == OFF_EP_SEL
        |=> regRdata[5:0] == sel_q) else $error("selector readback wrong");
    chk_cf_readback: assert property (regRd && regAddr == OFF_CTRL_FN
        |=> regRdata[4:2] == 3'h0 && regRdata[CF_STALL] == stall_q)
        else $error("control readback wrong");
    chk_busrst_keeps: assert property (usbBusReset && !regWr
        |=> irqLine == eventPending[IE_BRST]) else $error("bus reset enables");
    chk_rd_pulse: assert property (regRd |=> !regRd)
        else $error("read strobe longer than a cycle");
    chk_rd_wr_apart: assert property (!(regRd && regWr))
        else $error("read and write together");
    chk_rdata_hold: assert property (!regRd |=> $stable(regRdata))
        else $error("read data moved without a read");
    cover property (regWr && regAddr == OFF_EP_SEL);
    cover property (usbBusReset);
    cover property (irqLine);
endmodule : epir_chk

// *** tb/epir_tb.sv ***
// Testbench joining both ends through the register link
`timescale 1ns/1ps
module epir_tb
    import epir_pkg::*;
;
    logic clock, sys_rst, avs_read, avs_write, busRst;
    logic dataStageDone, statusDone, avs_waitrequest, irqQ;
    logic [7:0] avs_address, evP, evC, en, q, eventPending;
    logic [7:0] sv [5];
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] selEndpoint;
    logic selDirIn, selSetupBuf, selCtrlOut, selCtrlIn, selDataEp;
    logic dataStageEn, statusAck, stallEp;
    logic dataPortRd, dataPortWr, dataPortGo, flushP, validP;
    int nFlush = 0;
    int nValid = 0;
    int n_mismatch = 0;
    int tests_run = 0;
    epir_if link();
    epir_ctrl epir_ctrl_i (.clock(clock), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .link(link), .dataPortRd(dataPortRd), .dataPortWr(dataPortWr),
        .dataPortGo(dataPortGo));
    epir_device epir_device_i (.clock(clock), .sys_rst(sys_rst),
        .bus(link), .usbBusReset(busRst), .eventPulse(evP),
        .eventClear(evC), .dataStageDone(dataStageDone),
        .statusDone(statusDone), .selEndpoint(selEndpoint),
        .selDirIn(selDirIn), .selSetupBuf(selSetupBuf),
        .selCtrlOut(selCtrlOut), .selCtrlIn(selCtrlIn),
        .selDataEp(selDataEp), .flushPulse(flushP), .validatePulse(validP),
        .dataStageEn(dataStageEn), .statusAck(statusAck),
        .stallEp(stallEp), .eventPending(eventPending));
    epir_chk epir_chk_i (.clock(clock), .sys_rst(sys_rst),
        .usbBusReset(busRst), .regAddr(link.regAddr),
        .regWr(link.regWr), .regRd(link.regRd),
        .regWdata(link.regWdata), .regRdata(link.regRdata),
        .irqLine(link.irqLine), .eventPending(eventPending));
    assign irqQ = link.irqLine;
    // Command pulses are counted so a stuck or missing pulse shows up
    always_ff @(posedge clock) begin
        if (flushP) nFlush <= nFlush + 1;
        if (validP) nValid <= nValid + 1;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic g, input logic e);
        chk_byte({7'h00, g}, {7'h00, e});
    endtask : chk_bit
    // Holds the request until waitrequest is seen low, then releases
    task automatic bus(input logic w, input logic [7:0] a, d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n == 20) n_mismatch++;
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic rd(input logic [7:0] a, e);
        bus(1'b0, a, 8'h00);
        chk_byte(q, e);
    endtask : rd
    task automatic pulse(input logic [7:0] p, c, input logic r);
        evP <= p;
        evC <= c;
        busRst <= r;
        @(posedge clock);
        evP <= 8'h00;
        evC <= 8'h00;
        busRst <= 1'b0;
        @(posedge clock);
    endtask : pulse
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        final_report();
    end
    initial begin
        {sys_rst, avs_read, avs_write, busRst} = 4'h8;
        {dataStageDone, statusDone, avs_address, evP, evC} = '0;
        {dataPortRd, dataPortWr} = 2'b00;
        avs_writedata = '0;
        void'($urandom(88));
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rd(OFF_IRQ_EN, 8'h00);
        rd(OFF_EP_SEL, 8'h20);
        rd(OFF_CTRL_FN, 8'h00);
        rd(8'h40, 8'h00);
        $display("reset values done");
        for (int i = 0; i < NUM_EVT; i++) begin
            en = 8'($urandom) | (8'h01 << i);
            bus(1'b1, OFF_IRQ_EN, en);
            rd(OFF_IRQ_EN, en);
            pulse(8'h01 << i, 8'h00, 1'b0);
            chk_byte(eventPending, 8'h01 << i);
            chk_bit(irqQ, 1'b1);
            bus(1'b1, OFF_IRQ_EN, en ^ (8'h01 << i));
            chk_bit(irqQ, 1'b0);
            pulse(8'h00, 8'hFF, 1'b0);
        end
        $display("interrupt enables done");
        sv = '{8'h20, 8'h00, 8'h01, 8'h02, {3'h0, 5'($urandom)}};
        foreach (sv[k]) begin
            bus(1'b1, OFF_EP_SEL, sv[k]);
            rd(OFF_EP_SEL, sv[k]);
            chk_byte({4'h0, selEndpoint}, {4'h0, sv[k][4:1]});
            chk_bit(selDirIn, sv[k][0]);
            chk_bit(selSetupBuf, sv[k][5]);
            chk_bit(selCtrlOut, sv[k][5:0] == 6'h00);
            chk_bit(selCtrlIn, sv[k][5:0] == 6'h01);
            chk_bit(selDataEp, sv[k][4:1] != 4'h0);
        end
        $display("selector done");
        dataPortRd <= 1'b1;
        bus(1'b1, OFF_EP_SEL, 8'h02);
        @(negedge clock);
        chk_bit(dataPortGo, 1'b0);
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk_bit(dataPortGo, 1'b1);
        @(posedge clock);
        dataPortRd <= 1'b0;
        dataPortWr <= 1'b1;
        bus(1'b1, OFF_EP_SEL, 8'h03);
        @(negedge clock);
        chk_bit(dataPortGo, 1'b1);
        @(posedge clock);
        dataPortWr <= 1'b0;
        $display("data port guard done");
        bus(1'b1, OFF_CTRL_FN, 8'h1F);
        chk_byte({5'h00, dataStageEn, statusAck, stallEp}, 8'h07);
        chk_byte(8'(nFlush), 8'h01);
        chk_byte(8'(nValid), 8'h01);
        rd(OFF_CTRL_FN, 8'h03);
        dataStageDone <= 1'b1;
        statusDone <= 1'b1;
        @(posedge clock);
        dataStageDone <= 1'b0;
        statusDone <= 1'b0;
        @(posedge clock);
        chk_byte({6'h00, dataStageEn, statusAck}, 8'h00);
        rd(OFF_CTRL_FN, 8'h01);
        $display("control function done");
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, OFF_IRQ_EN, 8'hFF);
            bus(1'b1, OFF_EP_SEL, k ? 8'h21 : 8'h1E);
            pulse(8'h00, 8'h00, 1'b1);
            rd(OFF_IRQ_EN, 8'h01);
            rd(OFF_EP_SEL, k ? 8'h20 : 8'h00);
            rd(OFF_CTRL_FN, 8'h00);
            pulse(8'hFE, 8'h00, 1'b0);
            chk_bit(irqQ, 1'b0);
        end
        $display("bus reset done");
        final_report();
    end
endmodule : epir_tb
